// ### include/sice_consts.svh
`ifndef SICE_CONSTS_SVH
`define SICE_CONSTS_SVH
// ==========================================================================
// Register byte offsets
`define SICE_OFF_IR_CTRL 8'h00
`define SICE_OFF_EXT_SEL 8'h04
`define SICE_OFF_MODE 8'h08
`define SICE_OFF_DIVIDER 8'h0C
`define SICE_OFF_TX_DATA 8'h10
`define SICE_OFF_RX_DATA 8'h14
`define SICE_OFF_STATUS 8'h18
// ==========================================================================
// Field positions
`define SICE_MODE_TX_EN 0
`define SICE_MODE_RX_EN 1
`define SICE_MODE_CLOCK_SELECT_BIT1 2
`define SICE_MODE_SCARD 3
`define SICE_MODE_EXTCLK 4
`define SICE_ST_RX_VALID 0
`define SICE_ST_OVERRUN 1
`define SICE_ST_FRAME_ERR 2
`define SICE_ST_TX_BUSY 3
`define SICE_ST_FIFO_FULL 4
`define SICE_ST_FIFO_EMPTY 5
`define SICE_RX_VALID_BIT 8
// ==========================================================================
// Reset values
`define SICE_RST_IR_CTRL 4'h0
`define SICE_RST_EXT_SEL 4'h0
`define SICE_RST_MODE 5'h00
`define SICE_RST_DIVIDER 8'h00
// ==========================================================================
// Timing counts, in basic clocks per bit and accumulator steps
`define SICE_CORE_CLK_HZ 10_000_000
`define SICE_TPB_16X 9'h010
`define SICE_TPB_8X 9'h008
`define SICE_TPB_SCARD 9'h174
`define SICE_INC_115152 16'h2C38
`define SICE_INC_460606 16'h586F
`define SICE_INC_720_32M 16'h5C29
`define SICE_INC_115196 16'h1D7D
`define SICE_INC_460784 16'h75F6
`define SICE_INC_720_16M 16'h5C29
`endif

// ### include/sice_pkg.sv
package sice_pkg;
  typedef enum logic [1:0] {SICE_IDLE = 2'b00, SICE_START = 2'b01, SICE_DATA = 2'b10, SICE_STOP = 2'b11} sice_bit_st_t;

  typedef struct packed {
    logic [3:0] irc;
    logic [3:0] serial_extension_clock_select;
    logic [4:0] mode;
    logic [7:0] bit_rate_divider;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic rx_s1;
    logic rx_s2;
    logic [15:0] acc;
    logic [8:0] divcnt;
    logic tick;
    sice_bit_st_t txs;
    logic [8:0] tx_sub;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic [7:0] tx_cyc;
    logic tx_pin;
    sice_bit_st_t rxs;
    logic [8:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_samp;
    logic rx_seen;
    logic [7:0] rx_data;
    logic rx_valid;
    logic overrun;
    logic ferr;
  } sice_core_t;
endpackage

// ### rtl/sice_top.sv
// Behaviour
// - Infrared enable swaps shared pins to infrared coding
// - Pulse select sets infrared high pulse width
// - Infrared control bits 3..0 read zero
// - Extension register bits 7..4 ignore writes
// - Basic clock select: 16x or 8x
// - Average source overrides multiple when clock select set
// - Source code 000 uses external clock
// - Code 001: 115.152 kbps, 16x
// - Code 010: 460.606 kbps, 8x
// - Code 011: 720 kbps at 32 MHz, 16x
// - Code 101: 115.196 kbps, 16x; 100 reserved
// - Code 110: 460.784 kbps, 16x
// - Code 111: 720 kbps at 16 MHz, 8x
// - Smart card: 372 clocks, maximum rate clock/744
// - Receiver samples bit middle on eighth pulse at 16x, fourth pulse at 8x
`timescale 1ns/1ps
`include "sice_consts.svh"

// ==========================================================================
// Transmit FIFO
module sice_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i, // Core clock
  input wire logic arst_n_i, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Space available
  output logic [WIDTH-1:0] out_data_o, // Head word
  output logic out_valid_o, // Head word present
  input wire logic out_ready_i // Head word taken
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } sice_fifo_st_t;
  sice_fifo_st_t st;
  sice_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] level;

  assign level = st.wr - st.rd;
  assign in_ready_o = (level != (AW+1)'(DEPTH));
  assign out_valid_o = (st.wr != st.rd);
  assign out_data_o = mem[st.rd[AW-1:0]];

  always_comb
  begin
    next_st = st;
    if (in_valid_i && in_ready_o)
    begin
      next_st.wr = st.wr + 1'b1;
    end
    if (out_valid_o && out_ready_i)
    begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  // Storage carries no reset; pointers alone define what is valid.
  always_ff @(posedge core_clk_i)
  begin
    if (in_valid_i && in_ready_o)
    begin
      mem[st.wr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

// ==========================================================================
// Serial channel with infrared coding and clock extension
module sice_top
  import sice_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk_i, // Core clock, 10 MHz
  input wire logic arst_n_i, // Asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic shared_rx_pin_i, // Receive pin, plain or infrared
  input wire logic ext_clk_pin_i, // External basic clock
  output logic shared_tx_pin_o // Transmit pin, plain or infrared
);
  sice_core_t st;
  sice_core_t next_st;
  logic access;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic avg_on;
  logic ext_on;
  logic [8:0] tpb;
  logic uart_lvl;
  logic ir_lvl;
  logic ir_window;
  logic rx_line;
  logic rx_bitval;

  // ========================================================================
  // Clock source decode
  function automatic logic avg_active(input logic [4:0] mode, input logic [2:0] acs);
    avg_active = !mode[`SICE_MODE_SCARD] && mode[`SICE_MODE_CLOCK_SELECT_BIT1] && (acs != 3'b000) && (acs != 3'b100);
  endfunction

  function automatic logic [15:0] avg_inc(input logic [2:0] acs);
    case (acs)
      3'b001: avg_inc = `SICE_INC_115152;
      3'b010: avg_inc = `SICE_INC_460606;
      3'b011: avg_inc = `SICE_INC_720_32M;
      3'b101: avg_inc = `SICE_INC_115196;
      3'b110: avg_inc = `SICE_INC_460784;
      3'b111: avg_inc = `SICE_INC_720_16M;
      default: avg_inc = 16'h0000;
    endcase
  endfunction

  function automatic logic [8:0] avg_mult(input logic [2:0] acs);
    avg_mult = ((acs == 3'b010) || (acs == 3'b111)) ? `SICE_TPB_8X : `SICE_TPB_16X;
  endfunction

  assign avg_on = avg_active(st.mode, st.serial_extension_clock_select[2:0]);
  assign ext_on = st.mode[`SICE_MODE_EXTCLK] ||
                  (!st.mode[`SICE_MODE_SCARD] && st.mode[`SICE_MODE_CLOCK_SELECT_BIT1] && (st.serial_extension_clock_select[2:0] == 3'b000));

  always_comb
  begin
    if (st.mode[`SICE_MODE_SCARD])
    begin
      tpb = `SICE_TPB_SCARD;
    end
    else if (avg_on)
    begin
      tpb = avg_mult(st.serial_extension_clock_select[2:0]);
    end
    else
    begin
      tpb = st.serial_extension_clock_select[3] ? `SICE_TPB_8X : `SICE_TPB_16X;
    end
  end

  // ========================================================================
  // Line levels
  assign uart_lvl = (st.txs == SICE_START) ? 1'b0 : ((st.txs == SICE_DATA) ? st.tx_sh[0] : 1'b1);
  assign ir_window = (st.irc[2:0] == 3'b000) ? (st.tx_sub < 9'((tpb * 3) >> 4))
                                            : (st.tx_cyc < 8'(1 << st.irc[2:0]));
  assign ir_lvl = !uart_lvl && ir_window;
  // The infrared receiver idles low, so it is inverted to look like a plain line.
  assign rx_line = st.irc[3] ? !st.rx_s2 : st.rx_s2;
  assign rx_bitval = st.irc[3] ? !st.rx_seen : st.rx_samp;

  assign access = psel_i && penable_i && !st.pready;
  assign fifo_in_valid = access && pwrite_i && (paddr_i == `SICE_OFF_TX_DATA);
  // A frame starts on a basic clock tick, so its start bit is exactly as long as every other bit.
  assign fifo_pop = (st.txs == SICE_IDLE) && st.mode[`SICE_MODE_TX_EN] && fifo_valid && st.tick;

  sice_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .in_data_i(pwdata_i[7:0]),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // ========================================================================
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.ext_s1 = ext_clk_pin_i;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    next_st.rx_s1 = shared_rx_pin_i;
    next_st.rx_s2 = st.rx_s1;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // Basic clock tick.
    next_st.tick = 1'b0;
    if (ext_on)
    begin
      next_st.tick = st.ext_s2 && !st.ext_prev;
      next_st.acc = '0;
      next_st.divcnt = '0;
    end
    else if (avg_on)
    begin
      {next_st.tick, next_st.acc} = {1'b0, st.acc} + {1'b0, avg_inc(st.serial_extension_clock_select[2:0])};
      next_st.divcnt = '0;
    end
    else
    begin
      next_st.acc = '0;
      // Two core clocks per divider step
      if (st.divcnt >= {st.bit_rate_divider, 1'b1})
      begin
        next_st.divcnt = '0;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.divcnt = st.divcnt + 9'h001;
      end
    end
    // Register access; a full FIFO stalls the write by holding pready low.
    if (access && !(fifo_in_valid && !fifo_in_ready))
    begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      case (paddr_i)
        `SICE_OFF_IR_CTRL:
        begin
          next_st.prdata[7:4] = st.irc;
          if (pwrite_i)
          begin
            next_st.irc = pwdata_i[7:4];
          end
        end
        `SICE_OFF_EXT_SEL:
        begin
          next_st.prdata[3:0] = st.serial_extension_clock_select;
          if (pwrite_i)
          begin
            next_st.serial_extension_clock_select = pwdata_i[3:0];
          end
        end
        `SICE_OFF_MODE:
        begin
          next_st.prdata[4:0] = st.mode;
          if (pwrite_i)
          begin
            next_st.mode = pwdata_i[4:0];
          end
        end
        `SICE_OFF_DIVIDER:
        begin
          next_st.prdata[7:0] = st.bit_rate_divider;
          if (pwrite_i)
          begin
            next_st.bit_rate_divider = pwdata_i[7:0];
          end
        end
        `SICE_OFF_TX_DATA:
        begin
          next_st.prdata = '0;
        end
        `SICE_OFF_RX_DATA:
        begin
          next_st.prdata[8:0] = {st.rx_valid, st.rx_data};
          if (!pwrite_i)
          begin
            next_st.rx_valid = 1'b0;
          end
        end
        `SICE_OFF_STATUS:
        begin
          next_st.prdata[5:0] = {!fifo_valid, !fifo_in_ready, (st.txs != SICE_IDLE), st.ferr, st.overrun, st.rx_valid};
          if (pwrite_i)
          begin
            next_st.overrun = st.overrun && !pwdata_i[`SICE_ST_OVERRUN];
            next_st.ferr = st.ferr && !pwdata_i[`SICE_ST_FRAME_ERR];
          end
        end
        default:
        begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    // Transmitter.
    if (fifo_pop)
    begin
      next_st.txs = SICE_START;
      next_st.tx_sh = fifo_data;
      next_st.tx_sub = '0;
      next_st.tx_cyc = '0;
      next_st.tx_bit = '0;
    end
    else if (st.txs != SICE_IDLE)
    begin
      next_st.tx_cyc = (st.tx_cyc == 8'hFF) ? st.tx_cyc : st.tx_cyc + 8'h01;
      if (st.tick)
      begin
        next_st.tx_sub = st.tx_sub + 9'h001;
        if (st.tx_sub >= tpb - 9'h001)
        begin
          next_st.tx_sub = '0;
          next_st.tx_cyc = '0;
          case (st.txs)
            SICE_START: next_st.txs = SICE_DATA;
            SICE_DATA:
            begin
              next_st.tx_sh = {1'b1, st.tx_sh[7:1]};
              next_st.tx_bit = st.tx_bit + 3'h1;
              if (st.tx_bit == 3'h7)
              begin
                next_st.txs = SICE_STOP;
              end
            end
            default: next_st.txs = SICE_IDLE;
          endcase
        end
      end
    end
    next_st.tx_pin = st.irc[3] ? ir_lvl : uart_lvl;
    // Receiver.
    if (!st.mode[`SICE_MODE_RX_EN])
    begin
      next_st.rxs = SICE_IDLE;
    end
    else if (st.rxs == SICE_IDLE)
    begin
      if (!rx_line)
      begin
        next_st.rxs = SICE_START;
        next_st.rx_sub = '0;
        next_st.rx_bit = '0;
        next_st.rx_seen = 1'b1;
        next_st.rx_samp = 1'b1;
      end
    end
    else
    begin
      if (!rx_line)
      begin
        next_st.rx_seen = 1'b1;
      end
      if (st.tick)
      begin
        next_st.rx_sub = st.rx_sub + 9'h001;
        if (st.rx_sub == (tpb >> 1) - 9'h001)
        begin
          next_st.rx_samp = rx_line;
        end
        if (st.rx_sub >= tpb - 9'h001)
        begin
          next_st.rx_sub = '0;
          next_st.rx_seen = 1'b0;
          case (st.rxs)
            SICE_START: next_st.rxs = rx_bitval ? SICE_IDLE : SICE_DATA;
            SICE_DATA:
            begin
              next_st.rx_sh = {rx_bitval, st.rx_sh[7:1]};
              next_st.rx_bit = st.rx_bit + 3'h1;
              if (st.rx_bit == 3'h7)
              begin
                next_st.rxs = SICE_STOP;
              end
            end
            default:
            begin
              // An event here wins over a software clear in the same cycle.
              next_st.rxs = SICE_IDLE;
              if (!rx_bitval)
              begin
                next_st.ferr = 1'b1;
              end
              else if (st.rx_valid && next_st.rx_valid)
              begin
                next_st.overrun = 1'b1;
              end
              else
              begin
                next_st.rx_data = st.rx_sh;
                next_st.rx_valid = 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st <= '0;
      st.irc <= `SICE_RST_IR_CTRL;
      st.serial_extension_clock_select <= `SICE_RST_EXT_SEL;
      st.mode <= `SICE_RST_MODE;
      st.bit_rate_divider <= `SICE_RST_DIVIDER;
      st.tx_pin <= 1'b1;
      st.tx_sh <= 8'hFF;
      st.rx_samp <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign shared_tx_pin_o = st.tx_pin;

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence ir_ctrl_read;
    psel_i && penable_i && !pwrite_i && (paddr_i == `SICE_OFF_IR_CTRL) && !st.pready;
  endsequence
  sequence ext_sel_read;
    psel_i && penable_i && !pwrite_i && (paddr_i == `SICE_OFF_EXT_SEL) && !st.pready;
  endsequence

  pin_select_a: assert property (!st.irc[3] |=> shared_tx_pin_o == $past(uart_lvl))
    else $error("plain mode pin does not follow line level");
  ir_pulse_a: assert property (st.irc[3] && $past(st.irc[3]) && shared_tx_pin_o |-> !$past(uart_lvl))
    else $error("infrared pulse outside a zero bit");
  ir_reserved_a: assert property (ir_ctrl_read |=> pready_o && (prdata_o[3:0] == 4'h0))
    else $error("reserved low bits not zero");
  ext_upper_a: assert property (ext_sel_read |=> pready_o && (prdata_o[31:4] == 28'h0))
    else $error("extension upper bits not ignored");
  clock_mult_a: assert property (!st.mode[`SICE_MODE_SCARD] && !avg_on |-> tpb == (st.serial_extension_clock_select[3] ? 9'd8 : 9'd16))
    else $error("basic clock multiple wrong");
  avg_fix_a: assert property (avg_on && (st.serial_extension_clock_select[2:0] == 3'b111) |-> tpb == 9'd8)
    else $error("fixed multiple not applied");
  ext_tick_a: assert property (ext_on && $past(ext_on) && st.tick |-> $past(st.ext_s2 && !st.ext_prev))
    else $error("tick without external edge");
  avg_step_a: assert property (avg_on && !ext_on
    |=> st.acc == 16'($past(st.acc) + avg_inc($past(st.serial_extension_clock_select[2:0]))))
    else $error("average accumulator step wrong");
  scard_len_a: assert property (st.mode[`SICE_MODE_SCARD] |-> tpb == 9'd372)
    else $error("smart card bit length wrong");
  rx_mid_a: assert property (st.tick && (st.rxs != SICE_IDLE) && (st.rx_sub == 9'd7) && (tpb == 9'd16)
    && st.mode[`SICE_MODE_RX_EN] |=> st.rx_samp == $past(rx_line))
    else $error("receive sample not taken mid bit");
endmodule

// ### tb/sice_peer.sv
`timescale 1ns/1ps
// ====================
// Serial peer: line driver, frame monitor and external basic clock
module sice_peer (
  input wire logic core_clk_i, // Core clock
  input wire logic tx_pin_i, // Block transmit pin
  output logic rx_pin_o, // Block receive pin
  output logic ext_clk_o // External basic clock
);
  logic ext_run;
  int ext_cnt;

  initial
  begin
    rx_pin_o = 1'b1;
    ext_clk_o = 1'b0;
    ext_run = 1'b0;
    ext_cnt = 0;
  end

  always @(posedge core_clk_i)
  begin
    ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
    if (ext_cnt == 2)
      ext_clk_o <= ext_run & ~ext_clk_o;
  end

  // The clock stands still outside the frames that need it.
  task automatic ext_on(input logic on);
    ext_run = on;
  endtask

  task automatic idle(input logic lvl);
    rx_pin_o <= lvl;
  endtask

  task automatic send(input logic [7:0] d, input int bc, input bit ir);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_pin_o <= ir ? ~f[i] : f[i];
      repeat (ir ? bc * 3 / 16 : bc) @(posedge core_clk_i);
      if (ir)
      begin
        rx_pin_o <= 1'b0;
        repeat (bc - bc * 3 / 16) @(posedge core_clk_i);
      end
    end
  endtask

  // Plain frames are sampled mid-bit; pw returns the stop level.
  // Infrared frames return the start pulse width in core clocks.
  task automatic recv(input int bc, input bit ir, output logic [7:0] d, output int pw);
    int n;
    logic [9:0] seen;
    seen = '0;
    pw = 0;
    n = 0;
    if (ir)
    begin
      @(posedge core_clk_i iff tx_pin_i === 1'b1);
      while (n < 10 * bc)
      begin
        if (tx_pin_i === 1'b1)
          seen[n / bc] = 1'b1;
        if (n < bc && tx_pin_i === 1'b1)
          pw++;
        n++;
        @(posedge core_clk_i);
      end
      d = ~seen[8:1];
    end
    else
    begin
      @(posedge core_clk_i iff tx_pin_i === 1'b0);
      repeat (bc / 2) @(posedge core_clk_i);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bc) @(posedge core_clk_i);
        d[i] = tx_pin_i;
      end
      repeat (bc) @(posedge core_clk_i);
      pw = (tx_pin_i === 1'b1) ? 1 : 0;
    end
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "sice_consts.svh"
module testbench;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic rx_pin, ext_clk, tx_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] got;
  int pw, errors, num_checks;
  logic [31:0] rdv;
  logic errv;
  logic [3:0] ext_v [7] = '{4'h0, 4'h9, 4'h2, 4'hB, 4'hD, 4'hE, 4'h7};
  int bcs [7] = '{96, 93, 23, 44, 139, 35, 22};

  sice_top u_sice_top (.core_clk_i(core_clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .shared_rx_pin_i(rx_pin), .ext_clk_pin_i(ext_clk), .shared_tx_pin_o(tx_pin));
  sice_peer u_sice_peer (.core_clk_i(core_clk), .tx_pin_i(tx_pin), .rx_pin_o(rx_pin), .ext_clk_o(ext_clk));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ====================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 2000);
    rd = prdata;
    err = pslverr;
    if (n >= 2000)
      chk(32'h0, 32'h1, "bus hang");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x, s);
  endtask

  task automatic tx_chk(input logic [7:0] d, input int bc, input bit ir, input int pwx, input string s);
    logic [7:0] g;
    int p;
    fork
      u_sice_peer.recv(bc, ir, g, p);
      wr(`SICE_OFF_TX_DATA, {24'h0, d});
    join
    chk({24'h0, g}, {24'h0, d}, s);
    chk(32'(p), 32'(pwx), s);
  endtask

  initial
  begin
    repeat (80000) @(posedge core_clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  // ====================
  // Main sequence
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rdc(`SICE_OFF_IR_CTRL, '1, 32'h0000_0000, "ir reset");
    rdc(`SICE_OFF_EXT_SEL, 32'h0000_000F, 32'h0000_0000, "ext reset");
    wr(`SICE_OFF_IR_CTRL, 32'h0000_00FF);
    rdc(`SICE_OFF_IR_CTRL, '1, 32'h0000_00F0, "ir low bits");
    wr(`SICE_OFF_EXT_SEL, 32'h0000_00FF);
    rdc(`SICE_OFF_EXT_SEL, 32'h0000_000F, 32'h0000_000F, "ext bits");
    apb(1'b0, 8'h1C, 32'h0000_0000, rdv, errv);
    chk(rdv, 32'h0000_0000, "unmapped read");
    chk({31'h0, errv}, 32'h0000_0001, "unmapped error");
    chk({31'h0, pslverr}, 32'h0, "error idle");
    wr(`SICE_OFF_IR_CTRL, 32'h0000_0000);
    wr(`SICE_OFF_EXT_SEL, 32'h0000_0000);
    wr(`SICE_OFF_DIVIDER, 32'h0000_0000);
    wr(`SICE_OFF_MODE, 32'h0000_0003);
    tx_chk(8'hA5, 32, 1'b0, 1, "plain 16x");
    wr(`SICE_OFF_EXT_SEL, 32'h0000_0008);
    tx_chk(8'h3C, 16, 1'b0, 1, "plain 8x");
    wr(`SICE_OFF_EXT_SEL, 32'h0000_0000);
    u_sice_peer.send(8'hC3, 32, 1'b0);
    // The byte is stored only when the whole stop bit has passed.
    repeat (10) @(posedge core_clk);
    rdc(`SICE_OFF_RX_DATA, 32'h0000_01FF, 32'h0000_01C3, "plain rx");
    rdc(`SICE_OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "rx valid cleared");
    // Receiver off while the idle level of the line changes, to avoid a false start.
    wr(`SICE_OFF_MODE, 32'h0000_0001);
    wr(`SICE_OFF_DIVIDER, 32'h0000_0007);
    u_sice_peer.idle(1'b0);
    for (int c = 0; c < 8; c++)
    begin
      wr(`SICE_OFF_IR_CTRL, 32'h0000_0080 | (32'(c) << 4));
      tx_chk(8'h5A, 256, 1'b1, (c == 0) ? 48 : (1 << c), "ir width");
    end
    wr(`SICE_OFF_MODE, 32'h0000_0003);
    u_sice_peer.send(8'h96, 256, 1'b1);
    repeat (10) @(posedge core_clk);
    rdc(`SICE_OFF_RX_DATA, 32'h0000_01FF, 32'h0000_0196, "ir rx");
    wr(`SICE_OFF_MODE, 32'h0000_0005);
    wr(`SICE_OFF_IR_CTRL, 32'h0000_0000);
    u_sice_peer.idle(1'b1);
    for (int k = 0; k < 7; k++)
    begin
      wr(`SICE_OFF_EXT_SEL, {28'h0, ext_v[k]});
      u_sice_peer.ext_on(k == 0);
      tx_chk(8'hE7, bcs[k], 1'b0, 1, "average source");
    end
    wr(`SICE_OFF_MODE, 32'h0000_0011);
    u_sice_peer.ext_on(1'b1);
    tx_chk(8'h81, 96, 1'b0, 1, "forced external");
    u_sice_peer.ext_on(1'b0);
    wr(`SICE_OFF_MODE, 32'h0000_0000);
    wr(`SICE_OFF_DIVIDER, 32'h0000_0000);
    wr(`SICE_OFF_EXT_SEL, 32'h0000_0008);
    for (int i = 0; i < 32; i++)
      wr(`SICE_OFF_TX_DATA, 32'(i));
    rdc(`SICE_OFF_STATUS, 32'h0000_0038, 32'h0000_0010, "fifo full");
    fork
      for (int i = 0; i < 33; i++)
      begin
        u_sice_peer.recv(16, 1'b0, got, pw);
        chk({24'h0, got}, 32'(i), "fifo order");
      end
      begin
        wr(`SICE_OFF_MODE, 32'h0000_0001);
        wr(`SICE_OFF_TX_DATA, 32'd32);
      end
    join
    repeat (20) @(posedge core_clk);
    rdc(`SICE_OFF_STATUS, 32'h0000_0038, 32'h0000_0020, "fifo empty");
    wr(`SICE_OFF_EXT_SEL, 32'h0000_0000);
    wr(`SICE_OFF_MODE, 32'h0000_0009);
    tx_chk(8'h69, 744, 1'b0, 1, "smart card");
    end_of_test();
  end
endmodule
